// ===== rtl/dcf_pkg.sv
// Constants for the dual-channel fault and status register bank
package dcf_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_SWITCH_FAULT = 8'h03;
	localparam logic [7:0] ADDR_SUPPLY_THERMAL = 8'h04;
	localparam logic [7:0] ADDR_GLOBAL_STATUS = 8'h05;
	localparam logic [7:0] ADDR_TEMP_LIMIT = 8'h06;
	localparam logic [7:0] ADDR_LOW_POWER = 8'h07;
	localparam logic [7:0] ADDR_CH1_CUR_LO = 8'h08;
	localparam logic [7:0] ADDR_CH1_CUR_HI = 8'h09;
	localparam logic [7:0] ADDR_CH2_CUR_LO = 8'h0A;
	localparam logic [7:0] ADDR_CH2_CUR_HI = 8'h0B;
	localparam logic [7:0] ADDR_DIM_DIV = 8'h0C;
	localparam logic [7:0] ADDR_CH1_DIM_LO = 8'h0D;
	localparam logic [7:0] ADDR_CH1_DIM_HI = 8'h0E;
	localparam logic [7:0] ADDR_CH2_DIM_LO = 8'h0F;
	localparam logic [7:0] ADDR_CH2_DIM_HI = 8'h10;
	localparam logic [7:0] ADDR_CH1_ON_TIME = 8'h11;
	localparam logic [7:0] ADDR_CH2_ON_TIME = 8'h12;
	// Switch fault status field positions
	localparam int BIT_CH2_LS_OC = 7;
	localparam int BIT_CH2_HS_OC = 6;
	localparam int BIT_CH2_SHORT = 5;
	localparam int BIT_CH2_LOOP_OV = 4;
	localparam int BIT_CH1_LS_OC = 3;
	localparam int BIT_CH1_HS_OC = 2;
	localparam int BIT_CH1_SHORT = 1;
	localparam int BIT_CH1_LOOP_OV = 0;
	// Supply and thermal status field positions
	localparam int BIT_CH2_THERMAL = 5;
	localparam int BIT_CH2_BOOT = 4;
	localparam int BIT_CH2_MAX_DUTY = 3;
	localparam int BIT_CH1_THERMAL = 2;
	localparam int BIT_CH1_BOOT = 1;
	localparam int BIT_CH1_MAX_DUTY = 0;
	// Global status field positions
	localparam int BIT_STANDALONE = 7;
	localparam int BIT_ANALOG_LOW = 6;
	localparam int BIT_WDT_CNT_HI = 5;
	localparam int BIT_WDT_CNT_LO = 4;
	localparam int BIT_TEMP_WARN = 3;
	localparam int BIT_POWER_UP = 2;
	localparam int BIT_CH2_ANY = 1;
	localparam int BIT_CH1_ANY = 0;
	// Watchdog expiry count that forces limp-home
	localparam logic [1:0] WDT_CNT_LIMP = 2'h3;
	// Reset values
	localparam logic [7:0] RST_TEMP_LIMIT = 8'h8A;
	localparam logic [2:0] RST_DIM_DIV = 3'h4;
	localparam logic RST_POWER_UP = 1'b1;
	// Pending clear-on-read target
	typedef enum {PEND_NONE, PEND_S1, PEND_S2, PEND_S3} dcf_pend_t;
endpackage : dcf_pkg

// ===== rtl/dcf_status_bank.sv
// Fault and status register bank with control registers of a dual LED driver
`timescale 1ns/100ps

//Contract
// - Low-side overcurrent flags at bits 7/3
// - High-side overcurrent flags at bits 6/2
// - Output short flags at bits 5/1
// - Loop node overvoltage flags at bits 4/0
// - Thermal flags 5/2; channel restarts when cleared
// - Bootstrap low flags at bits 4/1
// - Max duty flags at bits 3/0
// - Standalone bit 7, cleared by command only
// - Analog supply low sets bit 6
// - Two-bit watchdog expiry count, saturating at 11
// - Count 11 forces limp-home mode
// - Temperature warning sets bit 3
// - Power-up flag resets to one, is fault
// - Power-up flag blocks channel enables
// - Bit 1 ORs channel two faults
// - Bit 0 ORs channel one faults
// - Second status bits 7-6 read zero
// - Control registers read and write
// - Current setting split low/high per channel
// - Divider and dim widths at 0x0C-0x10
// - On-time registers at 0x11, 0x12
// - Read clears flags whose cause has gone
// - Clear happens at read response end
module dcf_status_bank (
	input wire logic clk,
	input wire logic srst,
	// Register access from the serial framing logic
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rd_data,
	input wire logic rsp_done,
	// Analog detector inputs, asynchronous
	input wire logic ch1_lowside_overcurrent,
	input wire logic ch1_highside_overcurrent,
	input wire logic ch1_output_shorted,
	input wire logic ch1_loop_node_overvoltage,
	input wire logic ch1_thermal_shutdown,
	input wire logic ch1_bootstrap_low,
	input wire logic ch1_max_duty,
	input wire logic ch2_lowside_overcurrent,
	input wire logic ch2_highside_overcurrent,
	input wire logic ch2_output_shorted,
	input wire logic ch2_loop_node_overvoltage,
	input wire logic ch2_thermal_shutdown,
	input wire logic ch2_bootstrap_low,
	input wire logic ch2_max_duty,
	input wire logic analog_supply_low,
	// Same-clock inputs from neighbouring logic
	input wire logic [7:0] temp_adc_msb,
	input wire logic wdt_expired,
	input wire logic standalone_set,
	input wire logic standalone_clr,
	input wire logic ch1_enable_req,
	input wire logic ch2_enable_req,
	// Gated enables and mode outputs
	output logic ch1_enable,
	output logic ch2_enable,
	output logic limp_home,
	// Control register contents
	output logic [7:0] temp_warning_limit,
	output logic [1:0] low_power_request,
	output logic [9:0] ch1_current,
	output logic [9:0] ch2_current,
	output logic [2:0] dimming_clock_divider,
	output logic [15:0] ch1_dim_width,
	output logic [15:0] ch2_dim_width,
	output logic [7:0] ch1_on_time,
	output logic [7:0] ch2_on_time
);
	import dcf_pkg::*;

	logic [14:0] async_in; // Packed detector inputs
	logic [14:0] meta_q; // First synchroniser stage
	logic [14:0] sync_q; // Second synchroniser stage
	logic [7:0] s1_cause; // Switch fault causes
	logic [5:0] s2_cause; // Supply and thermal causes
	logic v5_cause; // Analog supply low cause
	logic warn_cause; // Temperature warning cause
	logic [7:0] s1_q; // Switch fault flags
	logic [5:0] s2_q; // Supply and thermal flags
	logic v5_q; // Analog supply low flag
	logic warn_q; // Temperature warning flag
	logic pwrup_q; // Power-up flag
	logic [1:0] wdt_cnt_q; // Watchdog expiry count
	logic standalone_q; // Stand-alone mode flag
	logic limp_q; // Limp-home latch
	logic ch1_any; // Channel one fault summary
	logic ch2_any; // Channel two fault summary
	dcf_pend_t pend_q; // Status register awaiting clear
	logic clr1; // Clear strobe for switch faults
	logic clr2; // Clear strobe for supply faults
	logic clr3; // Clear strobe for global flags
	logic [7:0] limit_q; // Warning limit
	logic [1:0] sleep_q; // Low-power request
	logic [9:0] cur1_q; // Channel one current
	logic [9:0] cur2_q; // Channel two current
	logic [2:0] div_q; // Dimming divider
	logic [15:0] dim1_q; // Channel one dim width
	logic [15:0] dim2_q; // Channel two dim width
	logic [7:0] ton1_q; // Channel one on-time
	logic [7:0] ton2_q; // Channel two on-time
	logic [7:0] rd_d; // Read mux
	logic [7:0] rd_q; // Read data register
	logic en1_q; // Gated channel one enable
	logic en2_q; // Gated channel two enable

	// True when the address equals the given target register
	function automatic logic is_write_hit(input logic [7:0] a, input logic [7:0] target);
		is_write_hit = (a == target);
	endfunction : is_write_hit

	// Pack detector pins for synchronising
	assign async_in = {analog_supply_low,
		ch2_thermal_shutdown, ch2_bootstrap_low, ch2_max_duty,
		ch1_thermal_shutdown, ch1_bootstrap_low, ch1_max_duty,
		ch2_lowside_overcurrent, ch2_highside_overcurrent, ch2_output_shorted, ch2_loop_node_overvoltage,
		ch1_lowside_overcurrent, ch1_highside_overcurrent, ch1_output_shorted, ch1_loop_node_overvoltage};

	// Two-flop synchroniser for every detector
	always_ff @(posedge clk) begin
		if (srst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	// Split synchronised causes into register layout
	assign s1_cause = sync_q[7:0];
	assign s2_cause = sync_q[13:8];
	assign v5_cause = sync_q[14];
	assign warn_cause = (temp_adc_msb > limit_q);

	// Clear strobes fire when the read response ends
	assign clr1 = rsp_done && (pend_q == PEND_S1);
	assign clr2 = rsp_done && (pend_q == PEND_S2);
	assign clr3 = rsp_done && (pend_q == PEND_S3);

	// Remember which status register was read
	always_ff @(posedge clk) begin
		if (srst) begin
			pend_q <= PEND_NONE;
		end else if (reg_rd_en) begin
			case (reg_addr)
				ADDR_SWITCH_FAULT: pend_q <= PEND_S1;
				ADDR_SUPPLY_THERMAL: pend_q <= PEND_S2;
				ADDR_GLOBAL_STATUS: pend_q <= PEND_S3;
				default: pend_q <= PEND_NONE;
			endcase
		end else if (rsp_done) begin
			pend_q <= PEND_NONE;
		end
	end

	// Switch fault flags: cause sets, read clears only gone causes
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_q <= '0;
		end else begin
			s1_q <= s1_cause | (s1_q & {8{~clr1}});
		end
	end

	// Supply and thermal flags
	always_ff @(posedge clk) begin
		if (srst) begin
			s2_q <= '0;
		end else begin
			s2_q <= s2_cause | (s2_q & {6{~clr2}});
		end
	end

	// Global single-bit flags
	always_ff @(posedge clk) begin
		if (srst) begin
			v5_q <= 1'b0;
			warn_q <= 1'b0;
			pwrup_q <= RST_POWER_UP;
		end else begin
			v5_q <= v5_cause | (v5_q & ~clr3);
			warn_q <= warn_cause | (warn_q & ~clr3);
			pwrup_q <= pwrup_q & ~clr3;
		end
	end

	// Watchdog expiry count, saturating; an expiry in the clear cycle restarts it at one
	always_ff @(posedge clk) begin
		if (srst) begin
			wdt_cnt_q <= '0;
		end else if (clr3) begin
			wdt_cnt_q <= wdt_expired ? 2'h1 : 2'h0;
		end else if (wdt_expired && (wdt_cnt_q != WDT_CNT_LIMP)) begin
			wdt_cnt_q <= wdt_cnt_q + 2'h1;
		end
	end

	// Limp-home latch, left only by reset
	always_ff @(posedge clk) begin
		if (srst) begin
			limp_q <= 1'b0;
		end else if (wdt_cnt_q == WDT_CNT_LIMP) begin
			limp_q <= 1'b1;
		end
	end

	// Stand-alone flag, immune to reads
	always_ff @(posedge clk) begin
		if (srst) begin
			standalone_q <= 1'b0;
		end else if (standalone_set) begin
			standalone_q <= 1'b1;
		end else if (standalone_clr) begin
			standalone_q <= 1'b0;
		end
	end

	// Per-channel summaries, warning excluded
	assign ch2_any = |s1_q[7:4] | s2_q[BIT_CH2_THERMAL] | s2_q[BIT_CH2_BOOT] | s2_q[BIT_CH2_MAX_DUTY];
	assign ch1_any = |s1_q[3:0] | s2_q[BIT_CH1_THERMAL] | s2_q[BIT_CH1_BOOT] | s2_q[BIT_CH1_MAX_DUTY];

	// Control register writes
	always_ff @(posedge clk) begin
		if (srst) begin
			limit_q <= RST_TEMP_LIMIT;
			sleep_q <= '0;
			cur1_q <= '0;
			cur2_q <= '0;
			div_q <= RST_DIM_DIV;
			dim1_q <= '0;
			dim2_q <= '0;
			ton1_q <= '0;
			ton2_q <= '0;
		end else if (reg_wr_en) begin
			// Status registers ignore writes
			if (is_write_hit(reg_addr, ADDR_TEMP_LIMIT)) limit_q <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_LOW_POWER)) sleep_q <= reg_wr_data[1:0];
			if (is_write_hit(reg_addr, ADDR_CH1_CUR_LO)) cur1_q[1:0] <= reg_wr_data[1:0];
			if (is_write_hit(reg_addr, ADDR_CH1_CUR_HI)) cur1_q[9:2] <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_CH2_CUR_LO)) cur2_q[1:0] <= reg_wr_data[1:0];
			if (is_write_hit(reg_addr, ADDR_CH2_CUR_HI)) cur2_q[9:2] <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_DIM_DIV)) div_q <= reg_wr_data[2:0];
			if (is_write_hit(reg_addr, ADDR_CH1_DIM_LO)) dim1_q[7:0] <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_CH1_DIM_HI)) dim1_q[15:8] <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_CH2_DIM_LO)) dim2_q[7:0] <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_CH2_DIM_HI)) dim2_q[15:8] <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_CH1_ON_TIME)) ton1_q <= reg_wr_data;
			if (is_write_hit(reg_addr, ADDR_CH2_ON_TIME)) ton2_q <= reg_wr_data;
		end
	end

	// Read mux; unmapped addresses return zero
	always_comb begin
		rd_d = 8'h00;
		case (reg_addr)
			ADDR_SWITCH_FAULT: rd_d = s1_q;
			ADDR_SUPPLY_THERMAL: rd_d = {2'h0, s2_q};
			ADDR_GLOBAL_STATUS: rd_d = {standalone_q, v5_q, wdt_cnt_q, warn_q, pwrup_q, ch2_any, ch1_any};
			ADDR_TEMP_LIMIT: rd_d = limit_q;
			ADDR_LOW_POWER: rd_d = {6'h00, sleep_q};
			ADDR_CH1_CUR_LO: rd_d = {6'h00, cur1_q[1:0]};
			ADDR_CH1_CUR_HI: rd_d = cur1_q[9:2];
			ADDR_CH2_CUR_LO: rd_d = {6'h00, cur2_q[1:0]};
			ADDR_CH2_CUR_HI: rd_d = cur2_q[9:2];
			ADDR_DIM_DIV: rd_d = {5'h00, div_q};
			ADDR_CH1_DIM_LO: rd_d = dim1_q[7:0];
			ADDR_CH1_DIM_HI: rd_d = dim1_q[15:8];
			ADDR_CH2_DIM_LO: rd_d = dim2_q[7:0];
			ADDR_CH2_DIM_HI: rd_d = dim2_q[15:8];
			ADDR_CH1_ON_TIME: rd_d = ton1_q;
			ADDR_CH2_ON_TIME: rd_d = ton2_q;
			default: rd_d = 8'h00;
		endcase
	end

	// Read data captured on the read command, held until the next
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_q <= 8'h00;
		end else if (reg_rd_en) begin
			rd_q <= rd_d;
		end
	end

	// Channel enables blocked by power-up flag and thermal protection
	always_ff @(posedge clk) begin
		if (srst) begin
			en1_q <= 1'b0;
			en2_q <= 1'b0;
		end else begin
			en1_q <= ch1_enable_req && !pwrup_q && !s2_q[BIT_CH1_THERMAL];
			en2_q <= ch2_enable_req && !pwrup_q && !s2_q[BIT_CH2_THERMAL];
		end
	end

	// Outputs straight from flops
	assign reg_rd_data = rd_q;
	assign ch1_enable = en1_q;
	assign ch2_enable = en2_q;
	assign limp_home = limp_q;
	assign temp_warning_limit = limit_q;
	assign low_power_request = sleep_q;
	assign ch1_current = cur1_q;
	assign ch2_current = cur2_q;
	assign dimming_clock_divider = div_q;
	assign ch1_dim_width = dim1_q;
	assign ch2_dim_width = dim2_q;
	assign ch1_on_time = ton1_q;
	assign ch2_on_time = ton2_q;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// Read command of the switch fault register, then its response end
	sequence s1_read_then_done;
		reg_rd_en && !rsp_done && (reg_addr == ADDR_SWITCH_FAULT) ##1 (!reg_rd_en && rsp_done);
	endsequence
	// Low-side cause on channel one gone at the response end
	sequence ch1_ls_gone_at_done;
		!s1_cause[BIT_CH1_LS_OC];
	endsequence

	chk_clear_after_resp: assert property (s1_read_then_done ##0 ch1_ls_gone_at_done |=> !s1_q[BIT_CH1_LS_OC])
		else $error("switch flag not cleared at response end");
	chk_flag_latch: assert property (s1_q[BIT_CH2_LS_OC] && !clr1 |=> s1_q[BIT_CH2_LS_OC])
		else $error("switch flag dropped without a read");
	chk_cause_kept: assert property (clr2 && s2_cause[BIT_CH2_BOOT] |=> s2_q[BIT_CH2_BOOT])
		else $error("persisting cause cleared by read");
	chk_cause_sets: assert property (s1_cause[BIT_CH1_HS_OC] |=> s1_q[BIT_CH1_HS_OC])
		else $error("high-side flag not set by cause");
	chk_power_block: assert property (pwrup_q |=> !ch1_enable && !ch2_enable)
		else $error("channel enabled while power-up flag set");
	chk_thermal_block: assert property (s2_q[BIT_CH1_THERMAL] |=> !ch1_enable)
		else $error("channel one enabled under thermal protection");
	chk_limp_entry: assert property (wdt_cnt_q == WDT_CNT_LIMP |=> limp_home)
		else $error("limp-home not entered at count three");
	chk_count_sat: assert property (wdt_cnt_q == WDT_CNT_LIMP && !clr3 |=> wdt_cnt_q == WDT_CNT_LIMP)
		else $error("expiry count left saturation");
	chk_count_step: assert property (wdt_expired && !clr3 && wdt_cnt_q == 2'h1 |=> wdt_cnt_q == 2'h2)
		else $error("expiry count did not step");
	chk_resv_zero: assert property (reg_rd_en && reg_addr == ADDR_SUPPLY_THERMAL |=> reg_rd_data[7:6] == 2'h0)
		else $error("reserved status bits not zero");
	chk_any_ch1: assert property (reg_rd_en && reg_addr == ADDR_GLOBAL_STATUS |=> reg_rd_data[0] == $past(ch1_any))
		else $error("channel one summary wrong");
	chk_standalone_hold: assert property (standalone_q && !standalone_clr |=> standalone_q)
		else $error("stand-alone flag cleared without command");
	chk_limit_write: assert property (reg_wr_en && reg_addr == ADDR_TEMP_LIMIT |=> temp_warning_limit == $past(reg_wr_data))
		else $error("warning limit write lost");
	// Power-up, stand-alone, count, summary, warning, thermal and write guards
	chk_pwrup_clear: assert property (clr3 |=> !pwrup_q)
		else $error("power-up flag not cleared by read");
	chk_pwrup_hold: assert property (pwrup_q && !clr3 |=> pwrup_q)
		else $error("power-up flag dropped without a read");
	chk_standalone_set: assert property (standalone_set |=> standalone_q)
		else $error("stand-alone flag not set");
	chk_any_ch2: assert property (reg_rd_en && reg_addr == ADDR_GLOBAL_STATUS |=> reg_rd_data[1] == $past(ch2_any))
		else $error("channel two summary wrong");
	chk_count_clear: assert property (clr3 && !wdt_expired |=> wdt_cnt_q == 2'h0)
		else $error("expiry count not cleared by read");
	chk_warn_sets: assert property (warn_cause |=> warn_q)
		else $error("temperature warning not set by cause");
	chk_thermal_ch2: assert property (s2_q[BIT_CH2_THERMAL] |=> !ch2_enable)
		else $error("channel two enabled under thermal protection");
	chk_on_time_write: assert property (reg_wr_en && reg_addr == ADDR_CH1_ON_TIME |=> ch1_on_time == $past(reg_wr_data))
		else $error("on-time write lost");
endmodule : dcf_status_bank

// ===== tb/dcf_host_model.sv
// Host-side model issuing register writes, reads and read-response ends
`timescale 1ns/100ps
module dcf_host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rd_data,
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic [7:0] reg_wr_data,
	output logic reg_rd_en,
	output logic rsp_done
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_wr_data = 8'h00;
		reg_rd_en = 1'b0;
		rsp_done = 1'b0;
	end
	// One-cycle write; released lines show inverted values
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk);
		#1;
		reg_addr = addr;
		reg_wr_data = data;
		reg_wr_en = 1'b1;
		@(posedge clk);
		#1;
		reg_wr_en = 1'b0;
		reg_addr = ~addr;
		reg_wr_data = ~data;
	endtask : write_reg
	// Read command, then optional response end after gap idle cycles
	task automatic read_reg(input logic [7:0] addr, input logic finish, input int gap, output logic [7:0] data);
		@(posedge clk);
		#1;
		reg_addr = addr;
		reg_rd_en = 1'b1;
		@(posedge clk);
		#1;
		reg_rd_en = 1'b0;
		reg_addr = ~addr;
		data = reg_rd_data;
		repeat (gap) begin
			@(posedge clk);
			#1;
		end
		// Response end is what lets flags clear
		if (finish) begin
			rsp_done = 1'b1;
			@(posedge clk);
			#1;
			rsp_done = 1'b0;
		end
	endtask : read_reg
endmodule : dcf_host_model

// ===== tb/test_dcf_status_bank.sv
// Self-checking bench for the fault and status register bank
`timescale 1ns/100ps
module test_dcf_status_bank;
	import dcf_pkg::*;
	logic clk = 1'b0; // 100 MHz clock
	logic srst = 1'b1; // Synchronous reset
	logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
	logic reg_wr_en, reg_rd_en, rsp_done;
	logic [13:0] det = 14'h0000; // Channel detectors in status bit order
	logic analog_supply_low = 1'b0, wdt_expired = 1'b0, standalone_set = 1'b0, standalone_clr = 1'b0;
	logic ch1_enable_req = 1'b0, ch2_enable_req = 1'b0;
	logic [7:0] temp_adc_msb = 8'h00;
	logic ch1_enable, ch2_enable, limp_home;
	logic [7:0] temp_warning_limit, ch1_on_time, ch2_on_time;
	logic [1:0] low_power_request;
	logic [9:0] ch1_current, ch2_current;
	logic [2:0] dimming_clock_divider;
	logic [15:0] ch1_dim_width, ch2_dim_width;
	int mismatches = 0; // Failed comparisons
	int checked = 0; // All comparisons
	// Clock generator
	always #5 clk = ~clk;
	dcf_host_model host (.clk(clk), .reg_rd_data(reg_rd_data), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .rsp_done(rsp_done));
	dcf_status_bank dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .rsp_done(rsp_done),
		.ch1_loop_node_overvoltage(det[0]), .ch1_output_shorted(det[1]), .ch1_highside_overcurrent(det[2]),
		.ch1_lowside_overcurrent(det[3]), .ch2_loop_node_overvoltage(det[4]), .ch2_output_shorted(det[5]),
		.ch2_highside_overcurrent(det[6]), .ch2_lowside_overcurrent(det[7]), .ch1_max_duty(det[8]),
		.ch1_bootstrap_low(det[9]), .ch1_thermal_shutdown(det[10]), .ch2_max_duty(det[11]),
		.ch2_bootstrap_low(det[12]), .ch2_thermal_shutdown(det[13]), .analog_supply_low(analog_supply_low),
		.temp_adc_msb(temp_adc_msb), .wdt_expired(wdt_expired), .standalone_set(standalone_set),
		.standalone_clr(standalone_clr), .ch1_enable_req(ch1_enable_req), .ch2_enable_req(ch2_enable_req),
		.ch1_enable(ch1_enable), .ch2_enable(ch2_enable), .limp_home(limp_home),
		.temp_warning_limit(temp_warning_limit), .low_power_request(low_power_request),
		.ch1_current(ch1_current), .ch2_current(ch2_current), .dimming_clock_divider(dimming_clock_divider),
		.ch1_dim_width(ch1_dim_width), .ch2_dim_width(ch2_dim_width), .ch1_on_time(ch1_on_time),
		.ch2_on_time(ch2_on_time));
	// Compare and count
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Read one register and compare
	task automatic rdchk(input logic [7:0] addr, input logic finish, input logic [7:0] exp);
		logic [7:0] data;
		host.read_reg(addr, finish, 0, data);
		check($sformatf("register %h", addr), {8'h00, exp}, {8'h00, data});
	endtask : rdchk
	// Let n edges pass, stop just after the last
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle
	// Verdict and end of run
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// Hang guard, far beyond the roughly 470 cycles needed
	initial begin
		#200000;
		mismatches++;
		$display("[FAIL] run expected done seen hang");
		finish_test();
	end
	// Main sequence
	initial begin
		int i;
		int b;
		logic [7:0] a;
		logic [7:0] m;
		logic [7:0] rd;
		idle(2);
		srst = 1'b0;
		idle(3);
		rdchk(8'h05, 0, 8'h04);
		rdchk(8'h04, 0, 8'h00);
		rdchk(8'h06, 0, 8'h8A);
		rdchk(8'h0C, 0, 8'h04);
		// Enables held off until the power-up flag is read clear
		ch1_enable_req = 1'b1;
		ch2_enable_req = 1'b1;
		idle(3);
		check("enables", 2'b00, {ch1_enable, ch2_enable});
		rdchk(8'h05, 1, 8'h04);
		idle(3);
		check("enables", 2'b11, {ch1_enable, ch2_enable});
		// Each channel detector: short event, latched, kept by command, cleared by response end
		for (i = 0; i < 14; i++) begin
			a = (i < 8) ? 8'h03 : 8'h04;
			b = (i < 8) ? i : i - 8;
			m = (i < 8) ? ((i >= 4) ? 8'h02 : 8'h01) : ((i >= 11) ? 8'h02 : 8'h01);
			det[i] = 1'b1;
			idle(5);
			det[i] = 1'b0;
			idle(5);
			rdchk(a, 0, 8'h01 << b);
			rdchk(8'h05, 0, m);
			if (i == 10 || i == 13) check("enables", (i == 10) ? 2'b01 : 2'b10, {ch1_enable, ch2_enable});
			rdchk(a, 1, 8'h01 << b);
			rdchk(a, 0, 8'h00);
			idle(2);
			check("enables", 2'b11, {ch1_enable, ch2_enable});
		end
		// Persisting cause survives a slow response end
		det[0] = 1'b1;
		det[12] = 1'b1;
		idle(5);
		host.read_reg(8'h03, 1, 4, rd);
		check("register 03", 16'h0001, {8'h00, rd});
		rdchk(8'h03, 0, 8'h01);
		rdchk(8'h04, 1, 8'h10);
		rdchk(8'h04, 0, 8'h10);
		det[0] = 1'b0;
		det[12] = 1'b0;
		idle(5);
		rdchk(8'h03, 1, 8'h01);
		rdchk(8'h03, 0, 8'h00);
		rdchk(8'h04, 1, 8'h10);
		rdchk(8'h04, 0, 8'h00);
		// Analog supply, temperature warning: none at the limit, set above it
		analog_supply_low = 1'b1;
		idle(5);
		analog_supply_low = 1'b0;
		idle(5);
		rdchk(8'h05, 1, 8'h40);
		rdchk(8'h05, 0, 8'h00);
		temp_adc_msb = 8'h8A;
		idle(3);
		rdchk(8'h05, 0, 8'h00);
		temp_adc_msb = 8'h8B;
		idle(3);
		rdchk(8'h05, 1, 8'h08);
		temp_adc_msb = 8'h00;
		rdchk(8'h05, 1, 8'h08);
		rdchk(8'h05, 0, 8'h00);
		// Standalone flag ignores reads, drops on command
		standalone_set = 1'b1;
		idle(1);
		standalone_set = 1'b0;
		rdchk(8'h05, 1, 8'h80);
		rdchk(8'h05, 0, 8'h80);
		standalone_clr = 1'b1;
		idle(1);
		standalone_clr = 1'b0;
		rdchk(8'h05, 0, 8'h00);
		// Watchdog expiries count up, saturate and force limp-home
		for (i = 1; i <= 4; i++) begin
			wdt_expired = 1'b1;
			idle(1);
			wdt_expired = 1'b0;
			m = (i > 3) ? 8'h30 : 8'(i << 4);
			rdchk(8'h05, 0, m);
			check("limp home", 16'(i >= 3), {15'h0000, limp_home});
		end
		rdchk(8'h05, 1, 8'h30);
		rdchk(8'h05, 0, 8'h00);
		// Control registers: write, read back with reserved bits zero
		for (i = 6; i <= 18; i++) begin
			a = 8'(i);
			case (i)
				7, 8, 10: m = 8'h03;
				12: m = 8'h07;
				default: m = 8'hFF;
			endcase
			host.write_reg(a, 8'h5A ^ a);
			rdchk(a, 0, (8'h5A ^ a) & m);
		end
		check("warning limit", {8'h00, 8'h5A ^ 8'h06}, {8'h00, temp_warning_limit});
		check("sleep", 16'h0001, {14'h0000, low_power_request});
		check("ch1 current", {6'h00, 8'h5A ^ 8'h09, 2'b10}, {6'h00, ch1_current});
		check("ch2 current", {6'h00, 8'h5A ^ 8'h0B, 2'b00}, {6'h00, ch2_current});
		check("divider", 16'h0006, {13'h0000, dimming_clock_divider});
		check("ch1 width", {8'h5A ^ 8'h0E, 8'h5A ^ 8'h0D}, ch1_dim_width);
		check("ch2 width", {8'h5A ^ 8'h10, 8'h5A ^ 8'h0F}, ch2_dim_width);
		check("on times", {8'h5A ^ 8'h11, 8'h5A ^ 8'h12}, {ch1_on_time, ch2_on_time});
		// Status is not writable, unmapped space reads zero
		host.write_reg(8'h03, 8'hFF);
		rdchk(8'h03, 0, 8'h00);
		host.write_reg(8'h20, 8'hFF);
		rdchk(8'h20, 0, 8'h00);
		finish_test();
	end
endmodule : test_dcf_status_bank
